// ---- logic/ffcu_core.sv ----
// Float format conversion unit of a shader ALU, one request per cycle
// Assumes the sequencer places legal slots; results reach the register file one cycle later
//
// How it works
// - Opcode 20 performs float floor on the source.
// - Floor truncates, then subtracts one for negative sources with a fraction.
// - Opcode 80 converts float to signed integer; toward zero only in slot 4 or under RM_ZERO.
// - Vector slots use the rounding mode state; transcendental slot always truncates.
// - Truncating signed: +inf gives max int; NaN and zeros give zero.
// - Truncating signed overflow keeps the low 32 bits.
// - Opcode 177 converts to signed integer toward negative infinity.
// - Floor and half-up signed saturate beyond unbiased exponent 30 by sign.
// - Floor signed: +inf/+NaN max, -inf/-NaN negated max, zeros zero.
// - Opcode 176 rounds to nearest, exact halves round upward.
// - Half-up signed: infinities and NaNs give max int, zeros give zero.
// - Opcode 154 truncates to unsigned, saturating beyond unbiased exponent 31.
// - Unsigned: -inf, NaN and zeros give zero; +inf gives max unsigned.
// - Opcode 174 packs four unsigned low bytes w,z,y,x high to low.
// - Packed conversion uses four vector slots and writes all four lanes.
// - Opcode 163 widens half in bits 15:0 with denormals and modifiers.
// - Opcode 162 narrows to half with denormals; no output modifiers.
// - Half narrowing and double widening take input modifiers only in slots 0, 2.
// - Double widening takes lane X or Z, writes lane pair YX or ZW; opcode 29 in slot 4 writes only the high word to lane 4.
// - Normal double keeps sign, rebiases exponent, shifts mantissa left 29.
// - NaN double copies sign, forces exponent ones, mantissa at top.
// - Infinities keep sign; zeros and denormals give signed double zero.
// - Single NaN with sign and top mantissa bit gives canonical double NaN.
// - Opcode 29 serves scalar use, opcode 206 vector use only.
`timescale 1ns/10ps
`include "ffcu_defs.svh"

module ffcu_core (
	input  logic                core_clk,
	input  logic                arst_n,
	input  ffcu_pkg::ffcu_req_t req,
	output ffcu_pkg::ffcu_rsp_t rsp
);
	import ffcu_pkg::*;

	logic [`FFCU_SLOTS-1:0][31:0] src_m;
	logic [`FFCU_SLOTS-1:0][31:0] fti_res;
	ffcu_fc_mode_t                lane_mode [0:`FFCU_SLOTS-1];
	logic                         mod_ok;
	logic [2:0]                   sl;
	logic [63:0]                  dbl;
	logic [31:0]                  packed_w;
	ffcu_rsp_t                    next_rsp;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	function automatic logic is_s2d(input logic [`FFCU_OPW-1:0] op);
		is_s2d = (op == `FFCU_OP_S2D_S) || (op == `FFCU_OP_S2D_V);
	endfunction

	function automatic logic [31:0] in_mod(input logic [31:0] f, input logic neg, input logic abs_v);
		in_mod = {neg ^ (f[31] & !abs_v), f[30:0]};
	endfunction

	function automatic ffcu_fc_mode_t mode_of(input logic [`FFCU_OPW-1:0] op, input logic trans);
		case (op)
			`FFCU_OP_TRUNC:  mode_of = trans ? FC_TRUNC : FC_STATE;
			`FFCU_OP_FLOORI: mode_of = FC_FLOOR;
			`FFCU_OP_HALFUP: mode_of = FC_HALF;
			`FFCU_OP_UNS:    mode_of = FC_UNS;
			`FFCU_OP_PACK:   mode_of = FC_UNS;
			default:         mode_of = FC_TRUNC;
		endcase
	endfunction

	function automatic logic [31:0] apply_output_scale_modifier(input logic [31:0] f, input logic [1:0] om);
		logic signed [9:0] e;
		e = $signed({2'h0, f[30:23]});
		case (om)
			`FFCU_OUTPUT_SCALE_MODIFIER_X2: e = e + 10'sh001;
			`FFCU_OUTPUT_SCALE_MODIFIER_X4: e = e + 10'sh002;
			`FFCU_OUTPUT_SCALE_MODIFIER_D2: e = e - 10'sh001;
			default:       e = e;
		endcase
		if (om == 2'h0 || f[30:23] == 8'h00 || f[30:23] == 8'hff) begin
			apply_output_scale_modifier = f;
		end else if (e >= 10'sh0ff) begin
			apply_output_scale_modifier = {f[31], 8'hff, 23'h0};
		end else if (e <= 10'sh000) begin
			apply_output_scale_modifier = {f[31], 31'h0};
		end else begin
			apply_output_scale_modifier = {f[31], e[7:0], f[22:0]};
		end
	endfunction

	function automatic logic [31:0] floor_f(input logic [31:0] f);
		logic signed [9:0] u;
		logic [23:0]       mask;
		logic [23:0]       trunc_m;
		logic [24:0]       sum;
		u       = $signed({2'h0, f[30:23]}) - `FFCU_F32_BIAS;
		mask    = 24'h7fffff >> u[4:0];
		trunc_m = {1'b1, f[22:0]} & ~mask;
		sum     = {1'b0, trunc_m} + {1'b0, mask} + 25'h0000001;
		if (f[30:23] == 8'h00) begin
			floor_f = {f[31], 31'h0};
		end else if (u >= 10'sh017) begin
			floor_f = f;
		end else if (u < 10'sh000) begin
			floor_f = f[31] ? `FFCU_F32_NEG_ONE : 32'h0;
		end else if (f[31] && (f[22:0] & mask[22:0]) != 23'h0) begin
			if (sum[24]) begin
				floor_f = {f[31], f[30:23] + 8'h01, sum[23:1]};
			end else begin
				floor_f = {f[31], f[30:23], sum[22:0]};
			end
		end else begin
			floor_f = {f[31], f[30:23], trunc_m[22:0]};
		end
	endfunction

	function automatic logic [31:0] h2s(input logic [15:0] h);
		integer     p;
		integer     i;
		logic [7:0] e;
		p = 0;
		for (i = 0; i < 10; i++) begin
			if (h[i]) begin
				p = i;
			end
		end
		e = 8'(p) + `FFCU_H2S_DENB;
		if (h[14:10] == 5'h1f) begin
			h2s = {h[15], 8'hff, h[9:0], 13'h0};
		end else if (h[14:10] != 5'h00) begin
			h2s = {h[15], {3'h0, h[14:10]} + `FFCU_H2S_REBIAS, h[9:0], 13'h0};
		end else if (h[9:0] == 10'h000) begin
			h2s = {h[15], 31'h0};
		end else begin
			h2s = {h[15], e, 23'({13'h0, h[9:0]} << (23 - p))};
		end
	endfunction

	function automatic logic [15:0] s2h(input logic [31:0] f);
		logic signed [9:0] u;
		logic [4:0]        sh;
		logic [47:0]       wide;
		logic [14:0]       body;
		u    = $signed({2'h0, f[30:23]}) - `FFCU_F32_BIAS;
		sh   = (u >= -10'sh00e) ? 5'h0d : 5'(-u - 10'sh001);
		wide = {1'b1, f[22:0], 24'h0} >> sh;
		if (u >= -10'sh00e) begin
			body = {5'(u + `FFCU_F16_BIAS), wide[33:24]};
		end else begin
			body = {5'h00, wide[33:24]};
		end
		body = body + {14'h0, wide[23] & ((|wide[22:0]) | wide[24])};
		if (f[30:23] == 8'hff) begin
			body = {5'h1f, f[22:0] != 23'h0, f[21:13]};
		end else if (f[30:23] == 8'h00 || u < -10'sh019) begin
			body = 15'h0000;
		end else if (u > `FFCU_F16_BIAS) begin
			body = {5'h1f, 10'h000};
		end
		s2h = {f[31], body};
	endfunction

	function automatic logic [63:0] s2d(input logic [31:0] f);
		if (f[30:23] == 8'hff) begin
			s2d = {f[31], 11'h7ff, f[22:0], {`FFCU_D_SHIFT{1'b0}}};
		end else if (f[30:23] == 8'h00) begin
			s2d = {f[31], 63'h0};
		end else begin
			s2d = {f[31], {3'h0, f[30:23]} + `FFCU_D_REBIAS, f[22:0], {`FFCU_D_SHIFT{1'b0}}};
		end
	endfunction

	// ------------------------------------------------------------
	// Source modifiers and lane converters
	// ------------------------------------------------------------
	assign sl = (req.slot > 3'h4) ? 3'h0 : req.slot;

	always_comb begin
		mod_ok = !(is_s2d(req.op) || req.op == `FFCU_OP_S2H) || req.slot == 3'h0 || req.slot == 3'h2;
		for (int i = 0; i < `FFCU_SLOTS; i++) begin
			src_m[i]     = mod_ok ? in_mod(req.src[i], req.in_neg, req.in_abs) : req.src[i];
			lane_mode[i] = mode_of(req.op, i == 4);
		end
	end

	genvar k;
	generate
		for (k = 0; k < `FFCU_SLOTS; k++) begin : g_lane
			ffcu_fti u_fti (
				.f      (src_m[k]),
				.mode   (lane_mode[k]),
				.rm     (req.rm),
				.result (fti_res[k])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Opcode decode and result steering
	// ------------------------------------------------------------
	always_comb begin
		next_rsp       = '0;
		next_rsp.valid = req.valid;
		next_rsp.op    = req.op;
		dbl            = s2d(src_m[sl]);
		packed_w       = {fti_res[3][7:0], fti_res[2][7:0], fti_res[1][7:0], fti_res[0][7:0]};
		if (req.valid && req.slot > 3'h4) begin
			next_rsp.illegal = 1'b1;
		end else if (req.valid) begin
			case (req.op)
				`FFCU_OP_FLOOR: begin
					next_rsp.data[sl] = apply_output_scale_modifier(floor_f(src_m[sl]), req.output_scale_modifier);
					next_rsp.we[sl]   = 1'b1;
				end
				`FFCU_OP_TRUNC, `FFCU_OP_FLOORI, `FFCU_OP_HALFUP, `FFCU_OP_UNS: begin
					next_rsp.data[sl] = fti_res[sl];
					next_rsp.we[sl]   = 1'b1;
				end
				`FFCU_OP_PACK: begin
					for (int i = 0; i < 4; i++) begin
						next_rsp.data[i] = packed_w;
					end
					next_rsp.we = 5'h0f;
				end
				`FFCU_OP_H2S: begin
					next_rsp.data[sl] = apply_output_scale_modifier(in_mod(h2s(req.src[sl][15:0]), req.in_neg, req.in_abs),
						req.output_scale_modifier);
					next_rsp.we[sl]   = 1'b1;
				end
				`FFCU_OP_S2H: begin
					next_rsp.data[sl] = {16'h0, s2h(src_m[sl])};
					next_rsp.we[sl]   = 1'b1;
				end
				`FFCU_OP_S2D_S, `FFCU_OP_S2D_V: begin
					if (sl == 3'h0 || sl == 3'h2) begin
						next_rsp.data[sl]          = dbl[31:0];
						next_rsp.data[3'(sl + 1)]  = dbl[63:32];
						next_rsp.we[sl]            = 1'b1;
						next_rsp.we[3'(sl + 1)]    = 1'b1;
					end else if (sl == 3'h4 && req.op == `FFCU_OP_S2D_S) begin
						next_rsp.data[4] = dbl[63:32];
						next_rsp.we[4]   = 1'b1;
					end else begin
						next_rsp.illegal = 1'b1;
					end
				end
				default: next_rsp.illegal = 1'b1;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Result register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp <= '0;
		end else begin
			rsp <= next_rsp;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_floor_minus_one: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_FLOOR && req.slot == 3'h0 && req.src[0] == 32'hbf000000
		&& !req.in_neg && !req.in_abs && req.output_scale_modifier == 2'h0 |=> rsp.we[0] && rsp.data[0] == `FFCU_F32_NEG_ONE)
		else $error("Floor of -0.5 did not give -1.0");

	a_trunc_posinf: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_TRUNC && req.slot == 3'h1 && req.src[1] == 32'h7f800000
		&& !req.in_neg && !req.in_abs |=> rsp.data[1] == `FFCU_MAX_INT)
		else $error("Truncating convert of +inf is not max int");

	a_trans_truncates: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_TRUNC && req.slot == 3'h4 && req.src[4] == 32'h3fc00000
		&& !req.in_neg && !req.in_abs |=> rsp.data[4] == 32'h00000001 && rsp.we == 5'h10)
		else $error("Transcendental slot did not truncate 1.5 to 1");

	a_floor_int_sat: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_FLOORI && req.slot == 3'h0 && req.src[0] == 32'hcf000000
		&& !req.in_neg && !req.in_abs |=> rsp.data[0] == `FFCU_NEG_MAX)
		else $error("Floor convert of -2^31 did not saturate");

	a_half_up_tie: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_HALFUP && req.slot == 3'h2 && req.src[2] == 32'hc0200000
		&& !req.in_neg && !req.in_abs |=> rsp.data[2] == 32'hfffffffe)
		else $error("Half-up convert of -2.5 is not -2");

	a_half_up_ninf: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_HALFUP && req.slot == 3'h3 && req.src[3] == 32'hff800000
		&& !req.in_neg && !req.in_abs |=> rsp.data[3] == `FFCU_MAX_INT)
		else $error("Half-up convert of -inf is not max int");

	a_uns_saturate: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_UNS && req.slot == 3'h0 && req.src[0] == 32'h4f800000
		&& !req.in_neg && !req.in_abs |=> rsp.data[0] == `FFCU_MAX_UINT)
		else $error("Unsigned convert of 2^32 did not saturate");

	a_pack_replicate: assert property (@(posedge core_clk) disable iff (!arst_n)
		rsp.valid && rsp.op == `FFCU_OP_PACK && !rsp.illegal |-> rsp.we == 5'h0f
		&& rsp.data[0] == rsp.data[1] && rsp.data[1] == rsp.data[2] && rsp.data[2] == rsp.data[3])
		else $error("Packed result not written to all four lanes");

	a_s2d_nan: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_S2D_V && req.slot == 3'h0 && req.src[0] == 32'hffc00000
		&& !req.in_neg && !req.in_abs |=> {rsp.data[1], rsp.data[0]} == 64'hfff8000000000000)
		else $error("Single NaN did not map to canonical double NaN");

	a_s2d_one: assert property (@(posedge core_clk) disable iff (!arst_n)
		req.valid && req.op == `FFCU_OP_S2D_S && req.slot == 3'h2 && req.src[2] == 32'h3f800000
		&& !req.in_neg && !req.in_abs |=> rsp.we == 5'h0c && rsp.data[3] == 32'h3ff00000 && rsp.data[2] == 32'h0)
		else $error("Single 1.0 did not widen to double 1.0 in lanes ZW");

endmodule

// ---- logic/ffcu_defs.svh ----
// Constants of the float format conversion unit: opcodes, special values, biases
// Assumes an 11-bit opcode field and five issue slots (four vector, one transcendental)
`ifndef FFCU_DEFS_SVH
`define FFCU_DEFS_SVH

`define FFCU_OPW         11
`define FFCU_SLOTS       5
`define FFCU_OP_FLOOR    11'h014
`define FFCU_OP_TRUNC    11'h050
`define FFCU_OP_FLOORI   11'h0b1
`define FFCU_OP_HALFUP   11'h0b0
`define FFCU_OP_UNS      11'h09a
`define FFCU_OP_PACK     11'h0ae
`define FFCU_OP_H2S      11'h0a3
`define FFCU_OP_S2H      11'h0a2
`define FFCU_OP_S2D_S    11'h01d
`define FFCU_OP_S2D_V    11'h0ce

`define FFCU_MAX_INT     32'h7fffffff
`define FFCU_NEG_MAX     32'h80000001
`define FFCU_TRUNC_NINF  32'h80000000
`define FFCU_MAX_UINT    32'hffffffff
`define FFCU_F32_NEG_ONE 32'hbf800000

`define FFCU_F32_BIAS    10'sh07f
`define FFCU_F16_BIAS    10'sh00f
`define FFCU_H2S_REBIAS  8'h70
`define FFCU_H2S_DENB    8'h67
`define FFCU_D_REBIAS    (11'h3ff - 11'h07f)
`define FFCU_D_SHIFT     29
`define FFCU_SAT_EXP_S   10'sh01e
`define FFCU_SAT_EXP_U   10'sh01f

`define FFCU_OUTPUT_SCALE_MODIFIER_X2     2'h1
`define FFCU_OUTPUT_SCALE_MODIFIER_X4     2'h2
`define FFCU_OUTPUT_SCALE_MODIFIER_D2     2'h3

`endif

// ---- logic/ffcu_fti.sv ----
// One float to integer lane converter, purely combinational
// Assumes the caller picks the mode per slot and registers the result
`timescale 1ns/10ps
`include "ffcu_defs.svh"

module ffcu_fti (
	input  logic [31:0]             f,
	input  ffcu_pkg::ffcu_fc_mode_t mode,
	input  ffcu_pkg::ffcu_rm_t      rm,
	output logic [31:0]             result
);
	import ffcu_pkg::*;

	logic              sgn;
	logic [7:0]        ex;
	logic signed [9:0] sh;
	logic [87:0]       fix;
	logic [31:0]       ip;
	logic [31:0]       mag;
	logic              hb;
	logic              st;
	logic              inc;

	// ------------------------------------------------------------
	// Magnitude, fraction and rounding increment
	// ------------------------------------------------------------
	always_comb begin
		sgn = f[31];
		ex  = f[30:23];
		sh  = $signed({2'h0, ex}) - `FFCU_F32_BIAS;
		fix = '0;
		hb  = 1'b0;
		st  = 1'b0;
		if (sh >= 10'sh000 && sh <= 10'sh03f) begin
			fix = {64'h0, 1'b1, f[22:0]} << sh[5:0];
			hb  = fix[22];
			st  = |fix[21:0];
		end else if (sh == -10'sh001) begin
			hb = 1'b1;
			st = |f[22:0];
		end else if (sh < -10'sh001) begin
			st = 1'b1;
		end
		ip = fix[54:23];
		case (mode)
			FC_FLOOR: inc = sgn & (hb | st);
			FC_HALF:  inc = sgn ? (hb & st) : hb;
			FC_STATE: begin
				case (rm)
					RM_NEAR: inc = hb & (st | ip[0]);
					RM_PINF: inc = !sgn & (hb | st);
					RM_NINF: inc = sgn & (hb | st);
					default: inc = 1'b0;
				endcase
			end
			default:  inc = 1'b0;
		endcase
		mag = ip + {31'h0, inc};
	end

	// ------------------------------------------------------------
	// Special values and saturation
	// ------------------------------------------------------------
	always_comb begin
		result = sgn ? -mag : mag;
		if (ex == 8'h00) begin
			result = '0;
		end else begin
			case (mode)
				FC_FLOOR: begin
					if (ex == 8'hff || sh > `FFCU_SAT_EXP_S) begin
						result = sgn ? `FFCU_NEG_MAX : `FFCU_MAX_INT;
					end
				end
				FC_HALF: begin
					if (ex == 8'hff) begin
						result = `FFCU_MAX_INT;
					end else if (sh > `FFCU_SAT_EXP_S) begin
						result = sgn ? `FFCU_NEG_MAX : `FFCU_MAX_INT;
					end
				end
				FC_UNS: begin
					if (ex == 8'hff) begin
						result = (f[22:0] == 23'h0 && !sgn) ? `FFCU_MAX_UINT : 32'h0;
					end else if (sgn) begin
						result = '0;
					end else if (sh > `FFCU_SAT_EXP_U) begin
						result = `FFCU_MAX_UINT;
					end else begin
						result = mag;
					end
				end
				default: begin
					if (ex == 8'hff) begin
						result = (f[22:0] != 23'h0) ? 32'h0 : (sgn ? `FFCU_TRUNC_NINF : `FFCU_MAX_INT);
					end
				end
			endcase
		end
	end

endmodule

// ---- logic/ffcu_pkg.sv ----
// Types of the float format conversion unit
// Assumes ffcu_defs.svh is on the include path
`include "ffcu_defs.svh"

package ffcu_pkg;

	// Conversion modes of one lane converter
	typedef enum logic [4:0] {
		FC_TRUNC = 5'h01,
		FC_STATE = 5'h02,
		FC_FLOOR = 5'h04,
		FC_HALF  = 5'h08,
		FC_UNS   = 5'h10
	} ffcu_fc_mode_t;

	// Rounding mode state of the vector slots
	typedef enum logic [1:0] {
		RM_NEAR = 2'h0,
		RM_PINF = 2'h1,
		RM_NINF = 2'h2,
		RM_ZERO = 2'h3
	} ffcu_rm_t;

	typedef struct packed {
		logic                      valid;
		logic [`FFCU_OPW-1:0]      op;
		logic [2:0]                slot;
		ffcu_rm_t                  rm;
		logic                      in_neg;
		logic                      in_abs;
		logic [1:0]                output_scale_modifier;
		logic [`FFCU_SLOTS-1:0][31:0] src;
	} ffcu_req_t;

	typedef struct packed {
		logic                      valid;
		logic [`FFCU_OPW-1:0]      op;
		logic                      illegal;
		logic [`FFCU_SLOTS-1:0]    we;
		logic [`FFCU_SLOTS-1:0][31:0] data;
	} ffcu_rsp_t;

endpackage

// ---- tb/ffcu_core_tb.sv ----
// Self-checking bench of the float format conversion unit
// Assumes one-cycle answer latency and the register file model beside the core
`timescale 1ns/10ps
`include "ffcu_defs.svh"

module ffcu_core_tb;
	import ffcu_pkg::*;

	logic                         core_clk;
	logic                         arst_n;
	ffcu_req_t                    req;
	ffcu_rsp_t                    rsp;
	ffcu_rsp_t                    got;
	logic [`FFCU_SLOTS-1:0][31:0] src_r;
	logic [`FFCU_SLOTS-1:0][31:0] gpr;
	logic [15:0]                  wr_cnt;
	logic [10:0]                  cur_op;
	int                           fail_count;
	int                           total_checks;
	int                           cycles = 0;

	ffcu_core dut_u (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.req      (req),
		.rsp      (rsp)
	);

	ffcu_rf_model rf_u (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.rsp      (rsp),
		.gpr      (gpr),
		.wr_cnt   (wr_cnt)
	);

	always #5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			fail_count++;
			close_out();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic ck(input string name, input logic [31:0] exp, input logic [31:0] seen);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One request, answer captured one cycle later
	task automatic go(input logic [2:0] slot, input ffcu_rm_t rm, input logic [3:0] mods, input logic [31:0] v);
		ffcu_req_t r;
		if (slot < 3'h5) begin
			src_r[slot] = v;
		end
		r = '0;
		r.valid = 1'b1;
		r.op = cur_op;
		r.slot = slot;
		r.rm = rm;
		{r.in_neg, r.in_abs, r.output_scale_modifier} = mods;
		r.src = src_r;
		@(posedge core_clk);
		req <= r;
		@(posedge core_clk);
		req.valid <= 1'b0;
		#1;
		got = rsp;
		ck("valid", 32'h1, {31'h0, got.valid});
		ck("op", {21'h0, cur_op}, {21'h0, got.op});
	endtask

	task automatic sc(input logic [2:0] slot, input ffcu_rm_t rm, input logic [3:0] mods,
		input logic [31:0] v, input logic [31:0] exp);
		go(slot, rm, mods, v);
		ck("we", 32'h1 << slot, {27'h0, got.we});
		ck("data", exp, got.data[slot]);
	endtask

	task automatic dc(input logic [2:0] slot, input logic [3:0] mods, input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		go(slot, RM_NEAR, mods, v);
		ck("we", 32'h3 << slot, {27'h0, got.we});
		ck("lo", lo, got.data[slot]);
		ck("hi", hi, got.data[slot+1]);
	endtask

	task automatic ill(input logic [2:0] slot);
		go(slot, RM_NEAR, 4'h0, 32'h3f800000);
		ck("illegal", 32'h1, {31'h0, got.illegal});
		ck("we", 32'h0, {27'h0, got.we});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_floor();
		cur_op = `FFCU_OP_FLOOR;
		sc(3'h0, RM_NEAR, 4'h0, 32'hc0200000, 32'hc0400000);
		sc(3'h4, RM_NEAR, 4'h0, 32'h40200000, 32'h40000000);
		sc(3'h1, RM_NEAR, 4'h0, 32'hc0000000, 32'hc0000000);
		sc(3'h2, RM_NEAR, 4'h1, 32'h40200000, 32'h40800000);
		sc(3'h3, RM_NEAR, 4'h8, 32'h40200000, 32'hc0400000);
		sc(3'h0, RM_NEAR, 4'h0, 32'hbf000000, 32'hbf800000);
		$display("test floor done");
	endtask

	task automatic t_trunc();
		cur_op = `FFCU_OP_TRUNC;
		sc(3'h4, RM_PINF, 4'h0, 32'h40200000, 32'h00000002);
		sc(3'h0, RM_PINF, 4'h0, 32'h40200000, 32'h00000003);
		sc(3'h0, RM_NEAR, 4'h0, 32'h40200000, 32'h00000002);
		sc(3'h1, RM_NINF, 4'h0, 32'hc0200000, 32'hfffffffd);
		sc(3'h3, RM_ZERO, 4'h0, 32'hc0200000, 32'hfffffffe);
		sc(3'h4, RM_NEAR, 4'h0, 32'h7f800000, 32'h7fffffff);
		sc(3'h1, RM_NEAR, 4'h0, 32'h7f800000, 32'h7fffffff);
		sc(3'h4, RM_PINF, 4'h0, 32'h3fc00000, 32'h00000001);
		sc(3'h4, RM_NEAR, 4'h0, 32'hff800000, 32'h80000000);
		sc(3'h4, RM_NEAR, 4'h0, 32'hffc00000, 32'h00000000);
		sc(3'h4, RM_NEAR, 4'h0, 32'h80000000, 32'h00000000);
		sc(3'h4, RM_NEAR, 4'h0, 32'h4f800001, 32'h00000200);
		sc(3'h4, RM_NEAR, 4'h0, 32'h4f000000, 32'h80000000);
		$display("test trunc done");
	endtask

	task automatic t_floori();
		cur_op = `FFCU_OP_FLOORI;
		sc(3'h1, RM_PINF, 4'h0, 32'hc0200000, 32'hfffffffd);
		sc(3'h1, RM_NEAR, 4'h0, 32'h4e800000, 32'h40000000);
		sc(3'h1, RM_NEAR, 4'h0, 32'h4f000000, 32'h7fffffff);
		sc(3'h1, RM_NEAR, 4'h0, 32'hcf000000, 32'h80000001);
		sc(3'h0, RM_NEAR, 4'h0, 32'hcf000000, 32'h80000001);
		sc(3'h1, RM_NEAR, 4'h0, 32'h7f800000, 32'h7fffffff);
		sc(3'h1, RM_NEAR, 4'h0, 32'h7fc00000, 32'h7fffffff);
		sc(3'h1, RM_NEAR, 4'h0, 32'hff800000, 32'h80000001);
		sc(3'h1, RM_NEAR, 4'h0, 32'hffc00000, 32'h80000001);
		sc(3'h1, RM_NEAR, 4'h0, 32'h80000000, 32'h00000000);
		$display("test floor int done");
	endtask

	task automatic t_halfup();
		cur_op = `FFCU_OP_HALFUP;
		sc(3'h2, RM_NINF, 4'h0, 32'h40200000, 32'h00000003);
		sc(3'h2, RM_NINF, 4'h0, 32'hc0200000, 32'hfffffffe);
		sc(3'h2, RM_NINF, 4'h0, 32'h3fe00000, 32'h00000002);
		sc(3'h2, RM_NINF, 4'h0, 32'h40100000, 32'h00000002);
		sc(3'h2, RM_NEAR, 4'h0, 32'h4f000000, 32'h7fffffff);
		sc(3'h2, RM_NEAR, 4'h0, 32'hcf000000, 32'h80000001);
		sc(3'h2, RM_NEAR, 4'h0, 32'hff800000, 32'h7fffffff);
		sc(3'h3, RM_NEAR, 4'h0, 32'hff800000, 32'h7fffffff);
		sc(3'h2, RM_NEAR, 4'h0, 32'hffc00000, 32'h7fffffff);
		sc(3'h2, RM_NEAR, 4'h0, 32'h80000000, 32'h00000000);
		$display("test half up done");
	endtask

	task automatic t_uns();
		cur_op = `FFCU_OP_UNS;
		sc(3'h3, RM_PINF, 4'h0, 32'h40780000, 32'h00000003);
		sc(3'h3, RM_NEAR, 4'h0, 32'h4f000000, 32'h80000000);
		sc(3'h3, RM_NEAR, 4'h0, 32'h4f800000, 32'hffffffff);
		sc(3'h0, RM_NEAR, 4'h0, 32'h4f800000, 32'hffffffff);
		sc(3'h3, RM_NEAR, 4'h0, 32'h7f800000, 32'hffffffff);
		sc(3'h3, RM_NEAR, 4'h0, 32'hff800000, 32'h00000000);
		sc(3'h3, RM_NEAR, 4'h0, 32'h7fc00000, 32'h00000000);
		sc(3'h3, RM_NEAR, 4'h0, 32'h80000000, 32'h00000000);
		$display("test unsigned done");
	endtask

	task automatic t_pack();
		logic [15:0] w0;
		cur_op = `FFCU_OP_PACK;
		src_r[1] = 32'h437f0000;
		src_r[2] = 32'h43800000;
		src_r[3] = 32'h41900000;
		go(3'h0, RM_NEAR, 4'h0, 32'h3f800000);
		ck("we", 32'h0000000f, {27'h0, got.we});
		w0 = wr_cnt;
		@(posedge core_clk);
		#1;
		ck("count", {16'h0, w0 + 16'h1}, {16'h0, wr_cnt});
		for (int k = 0; k < 4; k++) begin
			ck("pack", 32'h1200ff01, got.data[k]);
			ck("gpr", 32'h1200ff01, gpr[k]);
		end
		$display("test pack done");
	endtask

	task automatic t_half();
		cur_op = `FFCU_OP_H2S;
		sc(3'h1, RM_NEAR, 4'h0, 32'hdead3c00, 32'h3f800000);
		sc(3'h1, RM_NEAR, 4'h0, 32'h00000001, 32'h33800000);
		sc(3'h1, RM_NEAR, 4'h0, 32'h000003ff, 32'h387fc000);
		sc(3'h1, RM_NEAR, 4'h8, 32'h00003c00, 32'hbf800000);
		sc(3'h1, RM_NEAR, 4'h1, 32'h00003c00, 32'h40000000);
		sc(3'h1, RM_NEAR, 4'h2, 32'h00003c00, 32'h40800000);
		sc(3'h1, RM_NEAR, 4'h3, 32'h00003c00, 32'h3f000000);
		cur_op = `FFCU_OP_S2H;
		sc(3'h0, RM_NEAR, 4'h0, 32'h3f800000, 32'h00003c00);
		sc(3'h0, RM_NEAR, 4'h0, 32'h33800000, 32'h00000001);
		sc(3'h0, RM_NEAR, 4'h1, 32'h3f800000, 32'h00003c00);
		sc(3'h2, RM_NEAR, 4'h8, 32'h3f800000, 32'h0000bc00);
		sc(3'h1, RM_NEAR, 4'h8, 32'h3f800000, 32'h00003c00);
		sc(3'h3, RM_NEAR, 4'h4, 32'hbf800000, 32'h0000bc00);
		$display("test half convert done");
	endtask

	task automatic t_double();
		cur_op = `FFCU_OP_S2D_V;
		dc(3'h0, 4'h0, 32'h3f800000, 32'h00000000, 32'h3ff00000);
		dc(3'h0, 4'h0, 32'h3fc00001, 32'h20000000, 32'h3ff80000);
		dc(3'h2, 4'h0, 32'h00800000, 32'h00000000, 32'h38100000);
		dc(3'h2, 4'h0, 32'h7f800001, 32'h20000000, 32'h7ff00000);
		dc(3'h0, 4'h0, 32'hffc00000, 32'h00000000, 32'hfff80000);
		dc(3'h2, 4'h0, 32'h7f800000, 32'h00000000, 32'h7ff00000);
		dc(3'h0, 4'h0, 32'hff800000, 32'h00000000, 32'hfff00000);
		dc(3'h2, 4'h0, 32'h80000001, 32'h00000000, 32'h80000000);
		dc(3'h2, 4'h8, 32'h3f800000, 32'h00000000, 32'hbff00000);
		ill(3'h1);
		ill(3'h4);
		cur_op = `FFCU_OP_S2D_S;
		dc(3'h2, 4'h0, 32'h3f000000, 32'h00000000, 32'h3fe00000);
		dc(3'h2, 4'h0, 32'h3f800000, 32'h00000000, 32'h3ff00000);
		sc(3'h4, RM_NEAR, 4'h0, 32'h3f800000, 32'h3ff00000);
		ill(3'h5);
		cur_op = 11'h7ff;
		ill(3'h0);
		$display("test double done");
	endtask

	task automatic t_b2b();
		ffcu_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.op = `FFCU_OP_UNS;
		r.src[0] = 32'h40400000;
		@(posedge core_clk);
		req <= r;
		r.src[0] = 32'h40a00000;
		@(posedge core_clk);
		req <= r;
		#1;
		ck("first", 32'h3, rsp.data[0]);
		@(posedge core_clk);
		req.valid <= 1'b0;
		#1;
		ck("second", 32'h5, rsp.data[0]);
		@(posedge core_clk);
		#1;
		ck("idle", 32'h0, {31'h0, rsp.valid});
		@(posedge core_clk);
		req <= r;
		@(posedge core_clk);
		arst_n <= 1'b0;
		#1;
		ck("reset", 32'h0, {27'h0, rsp.we});
		ck("writes", 32'h0, {16'h0, wr_cnt});
		@(posedge core_clk);
		arst_n <= 1'b1;
		req.valid <= 1'b0;
		$display("test back to back done");
	endtask

	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		req = '0;
		src_r = '0;
		cur_op = 11'h0;
		fail_count = 0;
		total_checks = 0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		t_floor();
		t_trunc();
		t_floori();
		t_halfup();
		t_uns();
		t_pack();
		t_half();
		t_double();
		t_b2b();
		t_floor();
		close_out();
	end

endmodule

// ---- tb/ffcu_rf_model.sv ----
// Register file model standing behind the result port of the conversion unit
// Assumes rsp changes only on rising edges of core_clk
`timescale 1ns/10ps
`include "ffcu_defs.svh"

module ffcu_rf_model (
	input  logic                         core_clk,
	input  logic                         arst_n,
	input  ffcu_pkg::ffcu_rsp_t          rsp,
	output logic [`FFCU_SLOTS-1:0][31:0] gpr,
	output logic [15:0]                  wr_cnt
);
	import ffcu_pkg::*;

	// ----------------------------------------
	// Lane write-back
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gpr    <= '0;
			wr_cnt <= 16'h0;
		end else if (rsp.valid) begin
			for (int k = 0; k < `FFCU_SLOTS; k++) begin
				if (rsp.we[k]) begin
					gpr[k] <= rsp.data[k];
				end
			end
			wr_cnt <= wr_cnt + 16'h1;
		end
	end

endmodule
